// File: hw/gpio_ports.v
// five-port general purpose i/o block with shared functions, avalon-mm slave
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`include "gpio_ports_map.vh"
`timescale 1ns/1ps
`default_nettype none

module gpio_ports
#(
   parameter [17:0] OPEN_DRAIN_OPT = 18'h3_FFFF, // per bit, 1 = open-drain
   parameter        PORT_C_RST_HIGH = 1'b1,      // port C reset level
   parameter        PORT_D_RST_HIGH = 1'b1,      // port D reset level
   parameter        WATCHDOG_OPT    = 1'b0       // port E bit 1 as restart
)
(
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst_b,
   // avalon-mm slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // port A pins
   input  wire [3:0]  portABitsIn,
   output wire [3:0]  portABitsOut,
   output wire [3:0]  portABitsOe,
   output wire [3:0]  portABitsPu,
   // port C pins
   input  wire [3:0]  portCBitsIn,
   output wire [3:0]  portCBitsOut,
   output wire [3:0]  portCBitsOe,
   output wire [3:0]  portCBitsPu,
   // port D pins
   input  wire [3:0]  portDBitsIn,
   output wire [3:0]  portDBitsOut,
   output wire [3:0]  portDBitsOe,
   output wire [3:0]  portDBitsPu,
   // port E pins
   input  wire [1:0]  portEBitsIn,
   output wire [1:0]  portEBitsOut,
   output wire [1:0]  portEBitsOe,
   output wire [1:0]  portEBitsPu,
   // port F pins
   input  wire [3:0]  portFBitsIn,
   output wire [3:0]  portFBitsOut,
   output wire [3:0]  portFBitsOe,
   output wire [3:0]  portFBitsPu,
   // serial shifter side
   input  wire        serDataOut,
   input  wire        serClkOut,
   input  wire        serClkMaster,
   output reg         serDataIn_q,
   output reg         serClkIn_q,
   output reg         serEnable_q,
   output reg         serWide_q,
   // interrupt and standby side
   output reg         intSrcSerial_q,
   output reg         extIntReq_q,
   output reg         standby_q,
   output reg         watchdogRestart_q
);

   // ************************************************
   // declarations
   // ************************************************

   localparam [4:0] IDX_A = 5'h00; // flat bit index bases
   localparam [4:0] IDX_C = 5'h04;
   localparam [4:0] IDX_D = 5'h08;
   localparam [4:0] IDX_E = 5'h0C;
   localparam [4:0] IDX_F = 5'h0E;
   localparam NBITS = 18;

   wire [NBITS-1:0] pinIn;      // all pins, flat
   wire [NBITS-1:0] pinOut;     // drive values
   wire [NBITS-1:0] pinOe;      // drive enables
   wire [NBITS-1:0] pinPu;      // pull-up enables
   wire [NBITS-1:0] latch;      // output latches
   wire [NBITS-1:0] pinSync;    // synchronised pin levels
   reg  [NBITS-1:0] wrEn;       // latch write enables
   reg  [NBITS-1:0] wrVal;      // latch write values
   reg  [NBITS-1:0] fnEn;       // shared function active
   reg  [NBITS-1:0] fnVal;      // shared function level

   reg              sqrEn_q;    // square wave enable
   reg              intPinEn_q; // port F bit 3 as interrupt input
   reg  [5:0]       sqrCnt_q;   // half-period counter
   reg              sqrLvl_q;   // square wave level
   reg  [4:0]       testSel_q;  // bit chosen for testing

   wire             busReq;     // request present
   wire             busDo;      // request completes this edge
   reg  [31:0]      rdMux;      // read data source
   reg  [4:0]       selIdx;     // decoded bit-op index

   assign busReq = avs_read | avs_write;
   assign busDo  = busReq & ~avs_waitrequest;

   // flat pin vector: A, C, D, E, F from low to high
   assign pinIn = {portFBitsIn, portEBitsIn, portDBitsIn,
                   portCBitsIn, portABitsIn};

   // pin outputs are cell flip-flops, split back per port
   assign portABitsOut = pinOut[IDX_A+3:IDX_A];
   assign portABitsOe  = pinOe[IDX_A+3:IDX_A];
   assign portABitsPu  = pinPu[IDX_A+3:IDX_A];
   assign portCBitsOut = pinOut[IDX_C+3:IDX_C];
   assign portCBitsOe  = pinOe[IDX_C+3:IDX_C];
   assign portCBitsPu  = pinPu[IDX_C+3:IDX_C];
   assign portDBitsOut = pinOut[IDX_D+3:IDX_D];
   assign portDBitsOe  = pinOe[IDX_D+3:IDX_D];
   assign portDBitsPu  = pinPu[IDX_D+3:IDX_D];
   assign portEBitsOut = pinOut[IDX_E+1:IDX_E];
   assign portEBitsOe  = pinOe[IDX_E+1:IDX_E];
   assign portEBitsPu  = pinPu[IDX_E+1:IDX_E];
   assign portFBitsOut = pinOut[IDX_F+3:IDX_F];
   assign portFBitsOe  = pinOe[IDX_F+3:IDX_F];
   assign portFBitsPu  = pinPu[IDX_F+3:IDX_F];

   // ************************************************
   // port bit cells
   // ************************************************

   // reset level: C and D by option, all others high
   genvar gi;
   generate
      for (gi = 0; gi < NBITS; gi = gi + 1)
      begin : g_cell
         localparam RST_HI = (gi >= IDX_C && gi < IDX_D) ? PORT_C_RST_HIGH :
                             (gi >= IDX_D && gi < IDX_E) ? PORT_D_RST_HIGH :
                             1'b1;
         io_cell
         #(
            .OPEN_DRAIN (OPEN_DRAIN_OPT[gi]),
            .RESET_HIGH (RST_HI)
         )
         u_cell
         (
            .clk_sys   (clk_sys),
            .rst_b     (rst_b),
            .wrEn      (wrEn[gi]),
            .wrVal     (wrVal[gi]),
            .fnEn      (fnEn[gi]),
            .fnVal     (fnVal[gi]),
            .pinIn     (pinIn[gi]),
            .pinOut_q  (pinOut[gi]),
            .pinOe_q   (pinOe[gi]),
            .pinPu_q   (pinPu[gi]),
            .latch_q   (latch[gi]),
            .pinSync_q (pinSync[gi])
         );
      end
   endgenerate

   // ************************************************
   // bit selector decode
   // ************************************************

   // port code and bit number to flat index, none when invalid
   always @*
   begin
      selIdx = `BIT_NONE;
      case (avs_writedata[`SEL_PORT_HI:`SEL_PORT_LO])
         `PSEL_A: selIdx = IDX_A + {3'h0, avs_writedata[`SEL_BIT_HI:0]};
         `PSEL_C: selIdx = IDX_C + {3'h0, avs_writedata[`SEL_BIT_HI:0]};
         `PSEL_D: selIdx = IDX_D + {3'h0, avs_writedata[`SEL_BIT_HI:0]};
         `PSEL_E:
         begin
            if (!avs_writedata[`SEL_BIT_HI])
               selIdx = IDX_E + {4'h0, avs_writedata[`SEL_BIT_LO]};
         end
         `PSEL_F: selIdx = IDX_F + {3'h0, avs_writedata[`SEL_BIT_HI:0]};
         default: selIdx = `BIT_NONE;
      endcase
   end

   // ************************************************
   // latch write decode
   // ************************************************

   // port writes (four bits, two for port E) and single-bit set/clear
   always @*
   begin
      wrEn  = {NBITS{1'b0}};
      wrVal = {NBITS{1'b0}};
      if (busDo && avs_write)
      begin
         case (avs_address)
            `OFS_PORT_A:
            begin
               wrEn[IDX_A+3:IDX_A]  = 4'hF;
               wrVal[IDX_A+3:IDX_A] = avs_writedata[3:0];
            end
            `OFS_PORT_C:
            begin
               wrEn[IDX_C+3:IDX_C]  = 4'hF;
               wrVal[IDX_C+3:IDX_C] = avs_writedata[3:0];
            end
            `OFS_PORT_D:
            begin
               wrEn[IDX_D+3:IDX_D]  = 4'hF;
               wrVal[IDX_D+3:IDX_D] = avs_writedata[3:0];
            end
            `OFS_PORT_E:
            begin
               wrEn[IDX_E+1:IDX_E]  = 2'h3;
               wrVal[IDX_E+1:IDX_E] = avs_writedata[1:0];
            end
            `OFS_PORT_F:
            begin
               wrEn[IDX_F+3:IDX_F]  = 4'hF;
               wrVal[IDX_F+3:IDX_F] = avs_writedata[3:0];
            end
            `OFS_BIT_SET:
            begin
               if (selIdx != `BIT_NONE)
               begin
                  wrEn[selIdx]  = 1'b1;
                  wrVal[selIdx] = 1'b1;
               end
            end
            `OFS_BIT_CLR:
            begin
               if (selIdx != `BIT_NONE)
               begin
                  wrEn[selIdx]  = 1'b1;
                  wrVal[selIdx] = 1'b0;
               end
            end
            default:
            begin
               wrEn  = {NBITS{1'b0}};
               wrVal = {NBITS{1'b0}};
            end
         endcase
      end
   end

   // ************************************************
   // shared pin functions
   // ************************************************

   // function overrides; a released pin has its transistor off
   always @*
   begin
      fnEn  = {NBITS{1'b0}};
      fnVal = {NBITS{1'b1}};
      fnEn[IDX_E]  = sqrEn_q;
      fnVal[IDX_E] = sqrLvl_q;
      fnEn[IDX_E+1] = WATCHDOG_OPT;
      fnEn[IDX_F]   = serEnable_q;
      fnEn[IDX_F+1] = serEnable_q;
      fnVal[IDX_F+1] = serDataOut;
      fnEn[IDX_F+2] = serEnable_q;
      fnVal[IDX_F+2] = serClkOut | ~serClkMaster;
      fnEn[IDX_F+3] = intPinEn_q;
      // no square wave path exists toward port F
   end

   // ************************************************
   // square wave generator
   // ************************************************

   // toggles every half period, 64 instruction cycles a period
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sqrCnt_q <= 6'h00;
         sqrLvl_q <= 1'b1;
      end
      else if (!sqrEn_q)
      begin
         sqrCnt_q <= 6'h00;
         sqrLvl_q <= 1'b1;
      end
      else if ({26'h000_0000, sqrCnt_q} == `SQR_HALF_CLKS - 1)
      begin
         sqrCnt_q <= 6'h00;
         sqrLvl_q <= ~sqrLvl_q;
      end
      else
         sqrCnt_q <= sqrCnt_q + 6'h01;
   end

   // ************************************************
   // control register
   // ************************************************

   // software-set functions; serial and pin interrupt off at reset
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sqrEn_q        <= 1'b0;
         serEnable_q    <= 1'b0;
         serWide_q      <= 1'b0;
         intSrcSerial_q <= 1'b0;
         intPinEn_q     <= 1'b0;
         testSel_q      <= `BIT_NONE;
      end
      else if (busDo && avs_write)
      begin
         if (avs_address == `OFS_CTRL)
         begin
            sqrEn_q        <= avs_writedata[`CTL_SQR_EN];
            serEnable_q    <= avs_writedata[`CTL_SER_EN];
            serWide_q      <= avs_writedata[`CTL_SER_WIDE];
            intSrcSerial_q <= avs_writedata[`CTL_INT_SERIAL];
            intPinEn_q     <= avs_writedata[`CTL_INT_PIN_EN];
         end
         if (avs_address == `OFS_BIT_TEST)
            testSel_q <= selIdx;
      end
   end

   // ************************************************
   // standby and sampled inputs
   // ************************************************

   // standby entered by software, left when port A bit 3 reads low
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         standby_q         <= 1'b0;
         serDataIn_q       <= 1'b1;
         serClkIn_q        <= 1'b1;
         extIntReq_q       <= 1'b0;
         watchdogRestart_q <= 1'b0;
      end
      else
      begin
         if (busDo && avs_write && avs_address == `OFS_CTRL &&
             avs_writedata[`CTL_STANDBY])
            standby_q <= 1'b1;
         else if (!pinSync[IDX_A+3])
            standby_q <= 1'b0;
         serDataIn_q       <= pinSync[IDX_F] | ~serEnable_q;
         serClkIn_q        <= pinSync[IDX_F+2] | ~serEnable_q;
         extIntReq_q       <= intPinEn_q & ~pinSync[IDX_F+3];
         watchdogRestart_q <= WATCHDOG_OPT & ~pinSync[IDX_E+1];
      end
   end

   // ************************************************
   // read mux
   // ************************************************

   // port reads return pin levels, not latches
   always @*
   begin
      rdMux = 32'h0000_0000;
      case (avs_address)
         `OFS_PORT_A: rdMux[3:0] = pinSync[IDX_A+3:IDX_A];
         `OFS_PORT_C: rdMux[3:0] = pinSync[IDX_C+3:IDX_C];
         `OFS_PORT_D: rdMux[3:0] = pinSync[IDX_D+3:IDX_D];
         `OFS_PORT_E: rdMux[1:0] = pinSync[IDX_E+1:IDX_E];
         `OFS_PORT_F: rdMux[3:0] = pinSync[IDX_F+3:IDX_F];
         `OFS_BIT_TEST:
         begin
            if (testSel_q != `BIT_NONE)
            begin
               rdMux[0] = pinSync[testSel_q];
               rdMux[1] = ~pinSync[testSel_q];
            end
         end
         `OFS_CTRL:
         begin
            rdMux[`CTL_SQR_EN]     = sqrEn_q;
            rdMux[`CTL_SER_EN]     = serEnable_q;
            rdMux[`CTL_SER_WIDE]   = serWide_q;
            rdMux[`CTL_INT_SERIAL] = intSrcSerial_q;
            rdMux[`CTL_INT_PIN_EN] = intPinEn_q;
         end
         `OFS_STATUS:
         begin
            rdMux[`STS_STANDBY]  = standby_q;
            rdMux[`STS_WAKE_PIN] = pinSync[IDX_A+3];
            rdMux[`STS_WDT_PIN]  = pinSync[IDX_E+1];
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // ************************************************
   // bus handshake
   // ************************************************

   // one wait cycle: waitrequest drops for a single edge per access
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= ~(busReq & avs_waitrequest);
         if (avs_read && avs_waitrequest)
            avs_readdata <= rdMux;
      end
   end

endmodule // gpio_ports

`default_nettype wire

// File: hw/gpio_ports_map.vh
// register offsets, field positions, reset values and timing for the port block
`ifndef GPIO_PORTS_MAP_VH
`define GPIO_PORTS_MAP_VH

// ************************************************
// register byte offsets
// ************************************************
`define OFS_PORT_A      8'h00
`define OFS_PORT_C      8'h04
`define OFS_PORT_D      8'h08
`define OFS_PORT_E      8'h0C
`define OFS_PORT_F      8'h10
`define OFS_BIT_SET     8'h14
`define OFS_BIT_CLR     8'h18
`define OFS_BIT_TEST    8'h1C
`define OFS_CTRL        8'h20
`define OFS_STATUS      8'h24

// ************************************************
// bit-operation selector fields
// ************************************************
`define SEL_PORT_LO     4
`define SEL_PORT_HI     6
`define SEL_BIT_LO      0
`define SEL_BIT_HI      1
`define PSEL_A          3'h0
`define PSEL_C          3'h1
`define PSEL_D          3'h2
`define PSEL_E          3'h3
`define PSEL_F          3'h4
`define BIT_NONE        5'h1F

// ************************************************
// control register fields
// ************************************************
`define CTL_SQR_EN      0
`define CTL_SER_EN      1
`define CTL_SER_WIDE    2
`define CTL_INT_SERIAL  3
`define CTL_INT_PIN_EN  4
`define CTL_STANDBY     5
`define CTL_RESET       6'h00

// ************************************************
// status register fields
// ************************************************
`define STS_STANDBY     0
`define STS_WAKE_PIN    1
`define STS_WDT_PIN     2

// ************************************************
// timing
// ************************************************
`define SQR_PERIOD_TCYC 64
`define TCYC_CLKS       1
`define SQR_HALF_CLKS   ((`SQR_PERIOD_TCYC * `TCYC_CLKS) / 2)

`endif

// File: hw/io_cell.v
// one port bit: output latch, pin drive, pull-up option and input synchroniser
`timescale 1ns/1ps
`default_nettype none

module io_cell
#(
   parameter OPEN_DRAIN = 1'b1,  // 1 open-drain, 0 internal pull-up
   parameter RESET_HIGH = 1'b1   // latch level during and after reset
)
(
   // clock and reset
   input  wire clk_sys,
   input  wire rst_b,
   // latch write
   input  wire wrEn,
   input  wire wrVal,
   // shared function override
   input  wire fnEn,
   input  wire fnVal,
   // pin
   input  wire pinIn,
   output reg  pinOut_q,
   output reg  pinOe_q,
   output reg  pinPu_q,
   // state back to the port logic
   output reg  latch_q,
   output reg  pinSync_q
);

   reg meta_q;   // first synchroniser stage

   // ************************************************
   // output latch and pin drive
   // ************************************************

   // latch holds the written level; n-channel pulls low when level is 0
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         latch_q  <= RESET_HIGH;
         pinOe_q  <= ~RESET_HIGH;
         pinOut_q <= 1'b0;
         pinPu_q  <= 1'b0;
      end
      else
      begin
         if (wrEn)
            latch_q <= wrVal;
         pinOut_q <= 1'b0;           // only ever sinks
         pinPu_q  <= ~OPEN_DRAIN;
         if (fnEn)
            pinOe_q <= ~fnVal;       // shared function drives
         else if (wrEn)
            pinOe_q <= ~wrVal;
         else
            pinOe_q <= ~latch_q;
      end
   end

   // ************************************************
   // input synchroniser
   // ************************************************

   // two stages before any logic sees the pin
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q    <= 1'b1;
         pinSync_q <= 1'b1;
      end
      else
      begin
         meta_q    <= pinIn;
         pinSync_q <= meta_q;
      end
   end

endmodule // io_cell

`default_nettype wire

// File: sim/gpio_ports_properties.sv
// checker: assertions on the port block top ports
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_properties
#(
   parameter [17:0] OPEN_DRAIN_OPT = 18'h3_FFFF,
   parameter        WATCHDOG_OPT   = 1'b0
)
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_b,
   // bus
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   // pins
   input wire logic [3:0] portABitsIn,
   input wire logic [3:0] portFBitsIn,
   input wire logic [3:0] portABitsOut,
   input wire logic [3:0] portFBitsOut,
   input wire logic [3:0] portABitsPu,
   input wire logic [3:0] portFBitsPu,
   input wire logic [1:0] portEBitsOe,
   // side outputs
   input wire logic       standby_q,
   input wire logic       extIntReq_q,
   input wire logic       watchdogRestart_q,
   input wire logic       serEnable_q,
   input wire logic       serDataIn_q,
   input wire logic       serClkIn_q
);
   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   wait_answer_a: assert property
      ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   sink_only_a: assert property
      (portABitsOut == 4'h0 && portFBitsOut == 4'h0)
      else $error("pin driven high");
   pullup_opt_a: assert property ($past(rst_b) |->
      portABitsPu == ~OPEN_DRAIN_OPT[3:0] &&
      portFBitsPu == ~OPEN_DRAIN_OPT[17:14])
      else $error("pull-up option wrong");
   square_low_a: assert property ($rose(portEBitsOe[0])
      ##31 portEBitsOe[0] |=> !portEBitsOe[0])
      else $error("square wave low phase not 32");
   standby_wake_a: assert property
      (standby_q && !portABitsIn[3] |-> ##[1:4] !standby_q)
      else $error("standby not left on low pin");
   int_cause_a: assert property ($rose(extIntReq_q) |->
      !($past(portFBitsIn[3], 2) && $past(portFBitsIn[3], 3)
      && $past(portFBitsIn[3], 4)))
      else $error("interrupt with pin high");
   restart_off_a: assert property
      (WATCHDOG_OPT || !watchdogRestart_q)
      else $error("restart without option");
   serial_off_a: assert property
      (!serEnable_q && $past(!serEnable_q) |-> serDataIn_q && serClkIn_q)
      else $error("serial inputs active while off");
endmodule // gpio_ports_properties
bind gpio_ports gpio_ports_properties
   #(.OPEN_DRAIN_OPT(OPEN_DRAIN_OPT), .WATCHDOG_OPT(WATCHDOG_OPT)) i_props
(
   .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .portABitsIn(portABitsIn), .portFBitsIn(portFBitsIn),
   .portABitsOut(portABitsOut), .portFBitsOut(portFBitsOut),
   .portABitsPu(portABitsPu), .portFBitsPu(portFBitsPu),
   .portEBitsOe(portEBitsOe), .standby_q(standby_q),
   .extIntReq_q(extIntReq_q), .watchdogRestart_q(watchdogRestart_q),
   .serEnable_q(serEnable_q), .serDataIn_q(serDataIn_q),
   .serClkIn_q(serClkIn_q)
);
`default_nettype wire

// File: sim/ext_pins.sv
// model of the outside circuits on the eighteen port pins
`timescale 1ns/1ps
`default_nettype none
module ext_pins
(
   // clock
   input  wire logic        clk_sys,
   // device side
   input  wire logic [17:0] pinOe,
   input  wire logic [17:0] pinPu,
   // outside drivers
   input  wire logic [17:0] extEn,
   input  wire logic [17:0] extVal,
   // resolved levels
   output wire logic [17:0] pinLvl
);
   logic [17:0] floatPat = 18'h2_AAAA;  // undriven lines keep no level
   // pattern flips every cycle
   always @(posedge clk_sys)
      floatPat <= ~floatPat;
   // sink wins, then outside driver, then pull-up; clean edges only
   assign pinLvl = ~pinOe & ((extEn & extVal)
                   | (~extEn & (pinPu | floatPat)));
endmodule // ext_pins
`default_nettype wire

// File: sim/gpio_ports_tb.sv
// self-checking bench for the port block
`include "gpio_ports_map.vh"
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_tb;
   // ****************
   // signals
   // ****************
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic        serDataOut = 1'b1;
   logic        mst = 1'b0;
   logic [17:0] extEn = 18'h3_FFFF;   // outside pull-ups on all pins
   logic [17:0] extVal = 18'h3_FFFF;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [17:0] pinLvl, pinOe, pinPu, pinOut;  // order F E D C A
   wire  [3:0]  lowCOe, lowDOe;                // low-reset instance
   wire         serDataIn_q, serClkIn_q, serEnable_q, serWide_q;
   wire         intSrcSerial_q, extIntReq_q, standby_q, wdt;
   int          miscompares = 0;
   int          samples_checked = 0;
   logic [31:0] q;
   int          n;
   typedef struct packed
   {
      logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] rd;
   } row_t;
   // write address and data, then read address and expected data
   row_t rows [13] = '{
      '{`OFS_PORT_A, 32'h5, `OFS_PORT_A, 32'h5},
      '{`OFS_PORT_C, 32'hA, `OFS_PORT_C, 32'hA},
      '{`OFS_PORT_D, 32'h3, `OFS_PORT_D, 32'h3},
      '{`OFS_PORT_E, 32'h1, `OFS_PORT_E, 32'h1},
      '{`OFS_PORT_F, 32'h6, `OFS_PORT_F, 32'h6},
      '{`OFS_BIT_SET, 32'h01, `OFS_PORT_A, 32'h7},
      '{`OFS_BIT_CLR, 32'h00, `OFS_PORT_A, 32'h6},
      '{`OFS_BIT_SET, 32'h31, `OFS_PORT_E, 32'h3},
      '{`OFS_BIT_TEST, 32'h00, `OFS_BIT_TEST, 32'h2},
      '{`OFS_BIT_TEST, 32'h41, `OFS_BIT_TEST, 32'h1},
      '{`OFS_BIT_SET, 32'h70, `OFS_PORT_A, 32'h6},
      '{8'h30, 32'h5, 8'h30, 32'h0},
      '{`OFS_CTRL, 32'hC, `OFS_CTRL, 32'hC}};
   // ****************
   // design, second reset option, pins
   // ****************
   gpio_ports #(.OPEN_DRAIN_OPT(18'h2_A5A5)) i_dut
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .portABitsIn(pinLvl[3:0]), .portABitsOut(pinOut[3:0]),
      .portABitsOe(pinOe[3:0]), .portABitsPu(pinPu[3:0]),
      .portCBitsIn(pinLvl[7:4]), .portCBitsOut(pinOut[7:4]),
      .portCBitsOe(pinOe[7:4]), .portCBitsPu(pinPu[7:4]),
      .portDBitsIn(pinLvl[11:8]), .portDBitsOut(pinOut[11:8]),
      .portDBitsOe(pinOe[11:8]), .portDBitsPu(pinPu[11:8]),
      .portEBitsIn(pinLvl[13:12]), .portEBitsOut(pinOut[13:12]),
      .portEBitsOe(pinOe[13:12]), .portEBitsPu(pinPu[13:12]),
      .portFBitsIn(pinLvl[17:14]), .portFBitsOut(pinOut[17:14]),
      .portFBitsOe(pinOe[17:14]), .portFBitsPu(pinPu[17:14]),
      .serDataOut(serDataOut), .serClkOut(1'b0), .serClkMaster(mst),
      .serDataIn_q(serDataIn_q), .serClkIn_q(serClkIn_q),
      .serEnable_q(serEnable_q), .serWide_q(serWide_q),
      .intSrcSerial_q(intSrcSerial_q), .extIntReq_q(extIntReq_q),
      .standby_q(standby_q), .watchdogRestart_q(wdt)
   );
   gpio_ports #(.PORT_C_RST_HIGH(1'b0)) i_lowrst
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(),
      .avs_waitrequest(), .portABitsIn(pinLvl[3:0]), .portABitsOut(),
      .portABitsOe(), .portABitsPu(), .portCBitsIn(pinLvl[7:4]),
      .portCBitsOut(), .portCBitsOe(lowCOe), .portCBitsPu(),
      .portDBitsIn(pinLvl[11:8]), .portDBitsOut(), .portDBitsOe(lowDOe),
      .portDBitsPu(), .portEBitsIn(pinLvl[13:12]), .portEBitsOut(),
      .portEBitsOe(), .portEBitsPu(), .portFBitsIn(pinLvl[17:14]),
      .portFBitsOut(), .portFBitsOe(), .portFBitsPu(),
      .serDataOut(serDataOut), .serClkOut(1'b0), .serClkMaster(mst),
      .serDataIn_q(), .serClkIn_q(), .serEnable_q(), .serWide_q(),
      .intSrcSerial_q(), .extIntReq_q(), .standby_q(),
      .watchdogRestart_q()
   );
   ext_pins i_pins
   (
      .clk_sys(clk_sys), .pinOe(pinOe), .pinPu(pinPu), .extEn(extEn),
      .extVal(extVal), .pinLvl(pinLvl)
   );
   // ****************
   // tasks
   // ****************
   always #2 clk_sys = ~clk_sys;
   // compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   // one avalon access, held until waitrequest samples low
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0 && ++k < 50);
      if (k >= 50) miscompares++;
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      repeat (4) @(posedge clk_sys);  // pins settle through sync
   endtask
   // cycles until port E bit 0 sink reaches a level
   task automatic wait_oe(input logic lvl, output int c);
      c = 0;
      do
      begin
         @(posedge clk_sys);
         c++;
      end
      while (pinOe[12] !== lvl && c < 100);
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ****************
   // watchdog and main sequence
   // ****************
   initial
   begin
      #50000;
      miscompares++;
      close_out;
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      foreach (rows[i])
      begin
         bus(1'b1, rows[i].wa, rows[i].wd, q);
         bus(1'b0, rows[i].ra, 32'h0, q);
         chk(q, rows[i].rd);
      end
      chk({serWide_q, intSrcSerial_q, serEnable_q}, 3'b110);
      bus(1'b1, `OFS_CTRL, 32'h2, q);
      extVal[14] <= 1'b0;
      serDataOut <= 1'b0;
      mst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({serEnable_q, serWide_q, serDataIn_q}, 3'b100);
      chk(pinOe[15], 1'b1);
      chk(pinOe[16], 1'b1);
      extVal[17:14] <= 4'h7;
      serDataOut <= 1'b1;
      bus(1'b1, `OFS_CTRL, 32'h10, q);
      chk(extIntReq_q, 1'b1);
      extVal[17] <= 1'b1;
      bus(1'b1, `OFS_PORT_F, 32'hE, q);
      chk(extIntReq_q, 1'b0);
      bus(1'b1, `OFS_CTRL, 32'h1, q);
      wait_oe(1'b1, n);
      wait_oe(1'b0, n);
      chk(n, 32);
      wait_oe(1'b1, n);
      chk(n, 32);
      chk(pinOe[17:14], 4'h1);
      bus(1'b1, `OFS_PORT_A, 32'hF, q);
      bus(1'b1, `OFS_CTRL, 32'h20, q);
      chk(standby_q, 1'b1);
      bus(1'b0, `OFS_STATUS, 32'h0, q);
      chk(q, 32'h7);
      extVal[3] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk({standby_q, wdt}, 2'b00);
      extVal[3] <= 1'b1;
      rst_b <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(pinOe, 18'h0_0000);
      chk({lowCOe, lowDOe}, 8'hF0);
      chk({serEnable_q, intSrcSerial_q, serDataIn_q}, 3'b001);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      bus(1'b0, `OFS_PORT_A, 32'h0, q);
      chk(q, 32'hF);
      close_out;
   end
endmodule // gpio_ports_tb
`default_nettype wire
